/* rtl/sar_adc_pkg.sv */
/*
 * Shared constants and types for the SAR converter sequencer: register
 * offsets, field positions, reset values, mode and state encodings.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package sar_adc_pkg;

   // Bus and result widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int RES_W  = 12;

   // Register byte offsets
   localparam logic [7:0] OFF_CONTROL  = 8'h00;
   localparam logic [7:0] OFF_COMMAND  = 8'h04;
   localparam logic [7:0] OFF_STATUS   = 8'h08;
   localparam logic [7:0] OFF_RESULT   = 8'h0c;
   localparam logic [7:0] OFF_CHANNEL  = 8'h10;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFF_IRQ_CLR  = 8'h18;
   localparam logic [7:0] OFF_IRQ_EN   = 8'h1c;

   // Control register fields
   localparam int CTL_SRC_LSB  = 0;
   localparam int CTL_MODE_LSB = 3;
   localparam int CTL_EN_BIT   = 7;
   localparam int CTL_ACQ_LSB  = 8;
   localparam int CTL_SPD_LSB  = 10;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0600;
   localparam logic [31:0] CTRL_MASK = 32'h0000_1f9f;

   // Channel register fields
   localparam int CH_POS_LSB  = 0;
   localparam int CH_NEG_LSB  = 4;
   localparam int CH_TEMP_BIT = 8;
   localparam logic [31:0] CHAN_RST  = 32'h0000_0000;
   localparam logic [31:0] CHAN_MASK = 32'h0000_01ff;

   // Command, status and interrupt bits
   localparam int CMD_START_BIT = 0;
   localparam int CMD_STOP_BIT  = 1;
   localparam int STAT_READY    = 0;
   localparam int STAT_BUSY     = 1;
   localparam int IRQ_W         = 1;
   localparam int IRQ_DONE_BIT  = 0;
   localparam int RES_LSB       = 16;

   // Timing in ADC clocks
   localparam logic [4:0] CONV_CLKS = 5'h0e;
   localparam logic [3:0] PH_SETTLE = 4'h0;
   localparam logic [3:0] PH_WRITE  = 4'hd;
   localparam logic [2:0] SPD_MAX   = 3'h5;
   localparam logic [1:0] TEMP_ACQ  = 2'h3;
   localparam logic [2:0] TEMP_SPD  = 3'h5;

   // Negative mux code that selects analog ground
   localparam logic [3:0] NEG_GND = 4'hf;

   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MODE_DIFF   = 2'b00,
      MODE_SINGLE = 2'b01,
      MODE_PSEUDO = 2'b10
   } in_mode_t;

   typedef enum logic [2:0] {
      SRC_SW_SINGLE = 3'b000,
      SRC_SW_CONT   = 3'b001,
      SRC_EXT_PIN   = 3'b010,
      SRC_LOGIC     = 3'b011,
      SRC_TIMER_A   = 3'b100,
      SRC_TIMER_B   = 3'b101
   } trig_src_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACQ  = 2'b01,
      ST_CONV = 2'b10
   } conv_state_t;

endpackage

/* rtl/sar_approx_reg.sv */
/*
 * Successive approximation register: one bit trial per strobe, MSB first.
 * Assumes the comparator output is valid on the aclk domain at each trial.
 */
`timescale 1ns/10ps
`default_nettype none
module sar_approx_reg #(
   parameter int WIDTH = 12
) (
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Sequencing strobes
   input  wire logic             load,
   input  wire logic             trial,
   input  wire logic             comp_above,
   // Trial code and completion
   output logic [WIDTH-1:0]      code,
   output logic                  done
);

   logic [WIDTH-1:0] code_q, code_d;   // Current DAC code
   logic [WIDTH-1:0] ptr_q, ptr_d;     // One-hot bit under trial
   logic             done_q, done_d;   // All bits resolved

   // Next trial code
   always_comb
   begin
      code_d = code_q;
      ptr_d  = ptr_q;
      done_d = done_q;
      if (load)
      begin
         // Start at mid scale
         code_d = {1'b1, {(WIDTH-1){1'b0}}};
         ptr_d  = {1'b1, {(WIDTH-1){1'b0}}};
         done_d = 1'b0;
      end
      else if (trial && !done_q)
      begin
         // R1: keep or drop bit
         code_d = (comp_above ? code_q : (code_q & ~ptr_q)) | (ptr_q >> 1);
         ptr_d  = ptr_q >> 1;
         done_d = ptr_q[0];
      end
   end

   // State registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         code_q <= '0;
         ptr_q  <= '0;
         done_q <= 1'b0;
      end
      else
      begin
         code_q <= code_d;
         ptr_q  <= ptr_d;
         done_q <= done_d;
      end
   end

   assign code = code_q;
   assign done = done_q;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_sar_load_mid: assert property (load |=> code_q == {1'b1, {(WIDTH-1){1'b0}}} && !done_q) // R1
      else $error("Load did not set mid scale");
   a_sar_last_bit: assert property (trial && !load && !done_q && ptr_q[0] |=> done_q && ptr_q == '0) // R1
      else $error("Last trial did not finish");

endmodule // sar_approx_reg
`default_nettype wire

/* rtl/sar_adc_ctrl.sv */
/*
 * Conversion control for a 12-bit SAR converter, AXI4-Lite register slave.
 * Assumes timer and logic triggers share aclk; the start pin is asynchronous.
 */
// Operation
// R1: Resolve 12 bits by successive approximation.
// R2: Differential, single-ended, pseudo differential input pairing.
// R3: Software starts single or continuous conversions.
// R4: Hardware triggers: pin, logic, two timers.
// R5: Trigger still asserted at end restarts.
// R6: Extra selectable temperature sensor channel.
// R7: Straight binary result in non-differential modes.
// R8: Ready flag and interrupt; cleared reading result.
// R9: Busy output high throughout each conversion.
// R10: Fourteen ADC clocks plus acquisition; divided clock.
// R11: Acquisition of 2, 4, 8, 16 clocks.
// R12: Only the selected trigger source acts.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_ctrl import sar_adc_pkg::*; (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write channels
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Trigger sources
   input  wire logic              ext_convert_trigger_n,
   input  wire logic              programmable_logic_array_out,
   input  wire logic              general_timer_a_ovf,
   input  wire logic              general_timer_b_ovf,
   // Converter core
   input  wire logic              comp_above,
   output logic [RES_W-1:0]       dac_code,
   output logic                   sample_track,
   output logic [3:0]             mux_pos_sel,
   output logic [3:0]             mux_neg_sel,
   output logic                   temp_sensor_sel,
   output logic [1:0]             input_mode_out,
   // Status outputs
   output logic                   conversion_busy_out,
   output logic                   irq
);

   // Software registers
   logic [31:0]      ctrl_q, ctrl_d;         // converter_control_reg
   logic [31:0]      chan_q, chan_d;         // Channel selection
   logic [31:0]      result_q, result_d;     // conversion_result_reg
   logic             ready_q, ready_d;       // result_ready_flag
   logic [IRQ_W-1:0] irq_stat_q, irq_stat_d; // Sticky events
   logic [IRQ_W-1:0] irq_en_q, irq_en_d;     // Event enables
   logic             cont_q, cont_d;         // Continuous run armed
   logic             pend_q, pend_d;         // Timer overflow pending
   // Bus slave state
   logic             aw_full_q, aw_full_d;
   logic             w_full_q, w_full_d;
   logic [ADDR_W-1:0] waddr_q, waddr_d;
   logic [31:0]      wdata_q, wdata_d;
   logic [3:0]       wstrb_q, wstrb_d;
   logic             awready_q, awready_d, wready_q, wready_d;
   logic             bvalid_q, bvalid_d, arready_q, arready_d;
   logic             rvalid_q, rvalid_d;
   logic [1:0]       bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0]      rdata_q, rdata_d;
   // Sequencer state
   conv_state_t      state_q, state_d;
   logic [4:0]       div_q, div_d;           // Core clocks per ADC clock
   logic [4:0]       cnt_q, cnt_d;           // Acquisition clocks
   logic [3:0]       ph_q, ph_d;             // Conversion phase
   logic [4:0]       tcount_q, tcount_d;     // ADC clocks since start
   // Start pin synchroniser
   logic             ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q, ext_lvl_d;
   // Registered outputs
   logic             busy_q, busy_d, irq_q, irq_d, track_q, track_d;
   logic [3:0]       pos_q, pos_d, neg_q, neg_d;
   logic             temp_q, temp_d;
   logic [1:0]       mode_q, mode_d;
   // Decoded controls
   trig_src_t        src;
   in_mode_t         mode;
   logic [1:0]       acq_code;
   logic [2:0]       spd_code;
   logic             en, tick, req, last, start, wr_go, rd_go, sar_load, sar_trial;
   logic             sw_start, sw_stop, rd_result, timer_hit;
   logic [RES_W-1:0] sar_code;

   // Byte-lane merge for writable registers
   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] v;
      v = old_v;
      for (int i = 0; i < 4; i++)
         if (strb[i]) v[8*i +: 8] = new_v[8*i +: 8];
      return v & mask;
   endfunction

   // R10: divider terminal count, reserved codes clamp
   function automatic logic [4:0] div_limit(input logic [2:0] c);
      logic [2:0] s;
      s = (c > SPD_MAX) ? SPD_MAX : c;
      return 5'((6'h01 << s) - 6'h01);
   endfunction

   // R11: acquisition length in ADC clocks
   function automatic logic [4:0] acq_len(input logic [1:0] c);
      return 5'(5'h02 << c);
   endfunction

   assign src  = trig_src_t'(ctrl_q[CTL_SRC_LSB +: 3]);
   assign mode = in_mode_t'(ctrl_q[CTL_MODE_LSB +: 2]);
   assign en   = ctrl_q[CTL_EN_BIT];
   // R6: temperature channel forces slow timing
   assign acq_code = chan_q[CH_TEMP_BIT] ? TEMP_ACQ : ctrl_q[CTL_ACQ_LSB +: 2];
   assign spd_code = chan_q[CH_TEMP_BIT] ? TEMP_SPD : ctrl_q[CTL_SPD_LSB +: 3];

   // Bus commit strobes; write waits for both address and data
   assign wr_go     = aw_full_q && w_full_q && !bvalid_q;
   assign rd_go     = s_axi_arvalid && arready_q;
   assign sw_start  = wr_go && waddr_q == OFF_COMMAND && wstrb_q[0] && wdata_q[CMD_START_BIT];
   assign sw_stop   = wr_go && waddr_q == OFF_COMMAND && wstrb_q[0] && wdata_q[CMD_STOP_BIT];
   assign rd_result = rd_go && s_axi_araddr == OFF_RESULT;

   // Trigger selection and sequencing strobes
   always_comb
   begin
      // R12: only the selected source is looked at
      case (src)
         SRC_SW_SINGLE: req = sw_start;
         SRC_SW_CONT:   req = cont_q || sw_start;           // R3 continuous
         SRC_EXT_PIN:   req = ext_lvl_q;                    // R4 pin level
         SRC_LOGIC:     req = programmable_logic_array_out;
         SRC_TIMER_A:   req = pend_q;
         SRC_TIMER_B:   req = pend_q;
         default:       req = 1'b0;
      endcase
      timer_hit = (src == SRC_TIMER_A && general_timer_a_ovf) ||
                  (src == SRC_TIMER_B && general_timer_b_ovf);
      tick  = state_q != ST_IDLE && div_q == div_limit(spd_code);
      last  = state_q == ST_CONV && tick && ph_q == PH_WRITE;
      // R5: a request still present at the end restarts
      start = en && req && (state_q == ST_IDLE || last);
   end

   // Conversion sequencer next state
   always_comb
   begin
      state_d   = state_q;
      div_d     = tick ? 5'h00 : 5'(div_q + 5'h01);
      cnt_d     = cnt_q;
      ph_d      = ph_q;
      tcount_d  = tick ? 5'(tcount_q + 5'h01) : tcount_q;
      sar_load  = 1'b0;
      sar_trial = 1'b0;
      case (state_q)
         ST_IDLE:
         begin
            div_d = 5'h00;
            if (start)
            begin
               state_d  = ST_ACQ;
               cnt_d    = 5'h00;
               tcount_d = 5'h00;
            end
         end
         ST_ACQ:
         begin
            // R11: track for the programmed clocks
            if (tick && cnt_q == 5'(acq_len(acq_code) - 5'h01))
            begin
               state_d  = ST_CONV;
               ph_d     = PH_SETTLE;
               sar_load = 1'b1;
            end
            else if (tick)
               cnt_d = 5'(cnt_q + 5'h01);
         end
         ST_CONV:
         begin
            // R10: settle, twelve trials, write
            sar_trial = tick && ph_q != PH_SETTLE && ph_q != PH_WRITE;
            if (last)
            begin
               state_d  = start ? ST_ACQ : ST_IDLE;
               cnt_d    = 5'h00;
               tcount_d = 5'h00;
            end
            else if (tick)
               ph_d = 4'(ph_q + 4'h1);
         end
         default: state_d = ST_IDLE;
      endcase
      // Disabling aborts a conversion in flight
      if (!en)
         state_d = ST_IDLE;
   end

   // Register file, flags and bus next values
   always_comb
   begin
      ctrl_d = ctrl_q;  chan_d = chan_q;  irq_en_d = irq_en_q;
      aw_full_d = aw_full_q;  w_full_d = w_full_q;
      waddr_d = waddr_q;  wdata_d = wdata_q;  wstrb_d = wstrb_q;
      bvalid_d = bvalid_q && !s_axi_bready;
      bresp_d  = bresp_q;
      if (s_axi_awvalid && awready_q)
      begin
         aw_full_d = 1'b1;
         waddr_d   = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q)
      begin
         w_full_d = 1'b1;
         wdata_d  = s_axi_wdata;
         wstrb_d  = s_axi_wstrb;
      end
      if (wr_go)
      begin
         aw_full_d = 1'b0;
         w_full_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = RESP_OKAY;
         case (waddr_q)
            OFF_CONTROL: ctrl_d   = merge(ctrl_q, wdata_q, wstrb_q, CTRL_MASK);
            OFF_CHANNEL: chan_d   = merge(chan_q, wdata_q, wstrb_q, CHAN_MASK);
            OFF_IRQ_EN:  irq_en_d = IRQ_W'(merge(32'(irq_en_q), wdata_q, wstrb_q, 32'h1));
            OFF_COMMAND, OFF_IRQ_CLR: bresp_d = RESP_OKAY;
            default:     bresp_d  = RESP_SLVERR;
         endcase
      end
      // Hold off new address/data until the response is gone
      awready_d = !aw_full_d && !bvalid_d;
      wready_d  = !w_full_d && !bvalid_d;
      // Read channel: one outstanding read
      rvalid_d  = rvalid_q && !s_axi_rready;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      if (rd_go)
      begin
         rvalid_d = 1'b1;
         rresp_d  = RESP_OKAY;
         case (s_axi_araddr)
            OFF_CONTROL:  rdata_d = ctrl_q;
            OFF_CHANNEL:  rdata_d = chan_q;
            OFF_STATUS:   rdata_d = 32'({busy_q, ready_q});
            OFF_RESULT:   rdata_d = result_q;
            OFF_IRQ_STAT: rdata_d = 32'(irq_stat_q);
            OFF_IRQ_EN:   rdata_d = 32'(irq_en_q);
            OFF_COMMAND, OFF_IRQ_CLR: rdata_d = 32'h0000_0000;
            default:
            begin
               rdata_d = 32'h0000_0000;
               rresp_d = RESP_SLVERR;
            end
         endcase
      end
      arready_d = !rvalid_d;
      // R8: ready set at end, set beats clearing read
      ready_d    = (ready_q && !rd_result) || last;
      irq_stat_d = (irq_stat_q & ~((wr_go && waddr_q == OFF_IRQ_CLR && wstrb_q[0]) ?
                   wdata_q[IRQ_W-1:0] : {IRQ_W{1'b0}})) | {IRQ_W{last}};
      // R3: continuous run armed by start, ended by stop
      cont_d = (cont_q || (sw_start && src == SRC_SW_CONT)) && !sw_stop && src == SRC_SW_CONT;
      // R4: timer overflow held until a start consumes it
      pend_d = (pend_q && !start) || timer_hit;
      // R7: straight binary, else signed shifted right
      result_d = result_q;
      if (last)
         result_d = (mode == MODE_DIFF) ?
                    {{6{~sar_code[RES_W-1]}}, sar_code[RES_W-2:1], 16'h0000} :
                    {4'h0, sar_code, 16'h0000};
   end

   // Output next values
   always_comb
   begin
      // R9: busy follows the active sequence
      busy_d  = state_d != ST_IDLE;
      irq_d   = |(irq_stat_q & irq_en_q);
      track_d = state_d == ST_ACQ;
      // R2: single-ended ties the negative input to ground
      pos_d   = chan_q[CH_POS_LSB +: 4];
      neg_d   = (mode == MODE_SINGLE) ? NEG_GND : chan_q[CH_NEG_LSB +: 4];
      temp_d  = chan_q[CH_TEMP_BIT];
      mode_d  = mode;
      // Pin counts only once two later stages agree
      ext_lvl_d = (ext_s2_q == ext_s3_q) ? !ext_s3_q : ext_lvl_q;
   end

   // All state registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q <= CTRL_RST;  chan_q <= CHAN_RST;  result_q <= 32'h0000_0000;
         ready_q <= 1'b0;  irq_stat_q <= '0;  irq_en_q <= '0;
         cont_q <= 1'b0;  pend_q <= 1'b0;
         aw_full_q <= 1'b0;  w_full_q <= 1'b0;  waddr_q <= '0;
         wdata_q <= 32'h0000_0000;  wstrb_q <= 4'h0;
         awready_q <= 1'b0;  wready_q <= 1'b0;  bvalid_q <= 1'b0;
         arready_q <= 1'b0;  rvalid_q <= 1'b0;  bresp_q <= RESP_OKAY;
         rresp_q <= RESP_OKAY;  rdata_q <= 32'h0000_0000;
         state_q <= ST_IDLE;  div_q <= 5'h00;  cnt_q <= 5'h00;
         ph_q <= 4'h0;  tcount_q <= 5'h00;
         ext_s1_q <= 1'b1;  ext_s2_q <= 1'b1;  ext_s3_q <= 1'b1;  ext_lvl_q <= 1'b0;
         busy_q <= 1'b0;  irq_q <= 1'b0;  track_q <= 1'b0;
         pos_q <= 4'h0;  neg_q <= 4'h0;  temp_q <= 1'b0;  mode_q <= 2'h0;
      end
      else
      begin
         ctrl_q <= ctrl_d;  chan_q <= chan_d;  result_q <= result_d;
         ready_q <= ready_d;  irq_stat_q <= irq_stat_d;  irq_en_q <= irq_en_d;
         cont_q <= cont_d;  pend_q <= pend_d;
         aw_full_q <= aw_full_d;  w_full_q <= w_full_d;  waddr_q <= waddr_d;
         wdata_q <= wdata_d;  wstrb_q <= wstrb_d;
         awready_q <= awready_d;  wready_q <= wready_d;  bvalid_q <= bvalid_d;
         arready_q <= arready_d;  rvalid_q <= rvalid_d;  bresp_q <= bresp_d;
         rresp_q <= rresp_d;  rdata_q <= rdata_d;
         state_q <= state_d;  div_q <= div_d;  cnt_q <= cnt_d;
         ph_q <= ph_d;  tcount_q <= tcount_d;
         ext_s1_q <= ext_convert_trigger_n;  ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;  ext_lvl_q <= ext_lvl_d;
         busy_q <= busy_d;  irq_q <= irq_d;  track_q <= track_d;
         pos_q <= pos_d;  neg_q <= neg_d;  temp_q <= temp_d;  mode_q <= mode_d;
      end
   end

   // R1: bit trials in the approximation register
   sar_approx_reg #(.WIDTH(RES_W)) u_sar (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .load       (sar_load),
      .trial      (sar_trial),
      .comp_above (comp_above),
      .code       (sar_code),
      .done       ()
   );

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign dac_code            = sar_code;
   assign sample_track        = track_q;
   assign mux_pos_sel         = pos_q;
   assign mux_neg_sel         = neg_q;
   assign temp_sensor_sel     = temp_q;
   assign input_mode_out      = mode_q;
   assign conversion_busy_out = busy_q;
   assign irq                 = irq_q;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_conv_end;
      state_q == ST_CONV && tick && ph_q == PH_WRITE;
   endsequence
   sequence s_ready_up;
      ready_q && irq_stat_q[IRQ_DONE_BIT];
   endsequence

   a_ready_set: assert property (s_conv_end |=> s_ready_up) // R8
      else $error("Ready flag not set at conversion end");
   a_irq_raise: assert property (s_conv_end ##1 irq_en_q[IRQ_DONE_BIT] |=> irq) // R8
      else $error("Interrupt not raised after conversion end");
   a_conv_length: assert property (s_conv_end |-> 5'(tcount_q + 5'h01) == 5'(acq_len(acq_code) + CONV_CLKS)) // R10
      else $error("Conversion length wrong");
   a_busy_drop: assert property (s_conv_end ##0 !start |=> !conversion_busy_out && state_q == ST_IDLE) // R9
      else $error("Busy did not fall at end");
   a_retrigger: assert property (s_conv_end ##0 (en && req) |=> state_q == ST_ACQ ##1 conversion_busy_out) // R5
      else $error("Held trigger did not restart");
   a_sw_single: assert property (state_q == ST_IDLE && en && src == SRC_SW_SINGLE && sw_start |=> state_q == ST_ACQ) // R3
      else $error("Software start ignored");
   a_src_ignore: assert property (state_q == ST_IDLE && !req |=> state_q == ST_IDLE) // R12
      else $error("Conversion started without selected trigger");
   a_ext_pin_sync: assert property (ext_s2_q == ext_s3_q && !ext_s3_q |=> ext_lvl_q) // R4
      else $error("Start pin level not taken");
   a_se_pairing: assert property (mode == MODE_SINGLE |=> mux_neg_sel == NEG_GND) // R2
      else $error("Single-ended negative input not grounded");
   a_straight_bin: assert property (s_conv_end ##0 mode != MODE_DIFF |=> result_q[31:28] == 4'h0 && result_q[27:16] == $past(sar_code)) // R7
      else $error("Result not straight binary");
   a_acq_track: assert property (state_q == ST_ACQ ##1 state_q == ST_ACQ |-> sample_track) // R11
      else $error("Not tracking during acquisition");

endmodule // sar_adc_ctrl
`default_nettype wire

/* verif/sar_core_model.sv */
/* Converter core model: track-and-hold plus DAC comparator.
   Assumes dac_code and sample_track come straight from the sequencer. */
`timescale 1ns/10ps
`default_nettype none
module sar_core_model (
   // Clock and sequencer controls
   input  wire logic        aclk,
   input  wire logic        sample_track,
   input  wire logic [11:0] vin,
   input  wire logic [11:0] dac_code,
   // Comparator decision
   output logic             comp_above
);
   logic [11:0] held_q; // Sample held through the bit trials
   // hold then compare
   // Half-LSB offset puts code transitions midway between codes
   always @(posedge aclk)
      if (sample_track)
         held_q <= vin;
   assign comp_above = {held_q, 1'b1} > {dac_code, 1'b0};
endmodule // sar_core_model
`default_nettype wire

/* verif/sar_adc_conversion_control_tb_top.sv */
/* Bench for the SAR sequencer: AXI4-Lite tasks and trigger scenarios.
   Assumes the core model answers the comparator from the dac code. */
`timescale 1ns/10ps
`default_nettype none
module sar_adc_conversion_control_tb_top;
   import sar_adc_pkg::*;
   // Signals named as the dut ports
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf, mux_pos_sel, mux_neg_sel;
   logic s_axi_arvalid = 0, s_axi_rready = 0, ext_convert_trigger_n = 1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, input_mode_out, rs;
   logic programmable_logic_array_out = 0, general_timer_a_ovf = 0, general_timer_b_ovf = 0;
   logic comp_above, sample_track, temp_sensor_sel, conversion_busy_out, irq;
   logic [11:0] dac_code, vin = 12'ha5b;
   int failures = 0, total_checks = 0, cycles = 0, n;
   always #4 aclk = ~aclk;
   sar_adc_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .ext_convert_trigger_n, .programmable_logic_array_out,
      .general_timer_a_ovf, .general_timer_b_ovf, .comp_above, .dac_code, .sample_track,
      .mux_pos_sel, .mux_neg_sel, .temp_sensor_sel, .input_mode_out, .conversion_busy_out, .irq);
   sar_core_model i_core (.aclk, .sample_track, .vin, .dac_code, .comp_above);
   // Write: address and data together, each dropped once taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1;
      w = 1;
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      while (aw | w)
      begin
         @(posedge aclk);
         aw = aw & ~s_axi_awready;
         w = w & ~s_axi_wready;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
   endtask
   // Read: result left in rd and rs
   task rdr(input logic [7:0] a);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // Busy length in aclk cycles, waiting first for it to rise
   task conv();
      n = 0;
      while (conversion_busy_out !== 1'b1) @(posedge aclk);
      while (conversion_busy_out === 1'b1)
      begin
         @(posedge aclk);
         n++;
      end
   endtask
   // Edges with busy high over a fixed span
   task held(input int k);
      n = 0;
      repeat (k)
      begin
         @(posedge aclk);
         n += conversion_busy_out;
      end
   endtask
   task test_done();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Hang guard, well above the roughly 500 cycles needed
   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         failures++;
         test_done();
      end
   end
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
      rdr(OFF_CONTROL);
      chk(rd, CTRL_RST);
      rdr(8'h40);
      chk(rs, RESP_SLVERR);
      wr(OFF_IRQ_EN, 32'h1);
      wr(OFF_CHANNEL, 32'h153);
      @(posedge aclk);
      chk({temp_sensor_sel, mux_neg_sel, mux_pos_sel}, 9'h153);
      wr(OFF_CHANNEL, 32'h0);
      // Single-ended, software single, acquisition 16, divide by 2
      wr(OFF_CONTROL, 32'h788);
      @(posedge aclk);
      chk(input_mode_out, MODE_SINGLE);
      chk(mux_neg_sel, NEG_GND);
      wr(OFF_COMMAND, 32'h1);
      conv();
      chk(n >= 59 && n <= 62, 1'b1);
      @(posedge aclk);
      chk(irq, 1'b1);
      rdr(OFF_STATUS);
      chk(rd[0], 1'b1);
      rdr(OFF_RESULT);
      chk(rd, {4'h0, 12'ha5b, 16'h0});
      rdr(OFF_STATUS);
      chk(rd[0], 1'b0);
      wr(OFF_IRQ_CLR, 32'h1);
      @(posedge aclk);
      chk(irq, 1'b0);
      // Pseudo differential on timer A; timer B must be ignored
      wr(OFF_CONTROL, 32'h794);
      @(posedge aclk);
      chk(input_mode_out, MODE_PSEUDO);
      vin <= 12'h3c4;
      general_timer_b_ovf <= 1;
      @(posedge aclk);
      general_timer_b_ovf <= 0;
      repeat (5) @(posedge aclk);
      chk(conversion_busy_out, 1'b0);
      general_timer_a_ovf <= 1;
      @(posedge aclk);
      general_timer_a_ovf <= 0;
      conv();
      rdr(OFF_RESULT);
      chk(rd, {4'h0, 12'h3c4, 16'h0});
      // Differential, start pin held low across the end of a conversion
      wr(OFF_CONTROL, 32'h782);
      ext_convert_trigger_n <= 0;
      while (conversion_busy_out !== 1'b1) @(posedge aclk);
      held(64);
      chk(n, 64);
      ext_convert_trigger_n <= 1;
      conv();
      rdr(OFF_RESULT);
      chk(rd, 32'hfde2_0000);
      // Continuous software run until the stop command
      wr(OFF_CONTROL, 32'h789);
      wr(OFF_COMMAND, 32'h1);
      held(64);
      chk(n, 64);
      wr(OFF_COMMAND, 32'h2);
      conv();
      repeat (4) @(posedge aclk);
      chk(conversion_busy_out, 1'b0);
      test_done();
   end
endmodule // sar_adc_conversion_control_tb_top
`default_nettype wire
